/* design/agp_regs.svh */
`ifndef AGP_REGS_SVH
`define AGP_REGS_SVH

// register offsets
`define AGP_ADDR_FUNC01   8'h10
`define AGP_ADDR_FUNC23   8'h11
`define AGP_ADDR_DIR01    8'h12
`define AGP_ADDR_DIR23    8'h13
`define AGP_ADDR_STATE    8'h14
`define AGP_ADDR_PULL     8'h15

// reset values
`define AGP_RST_FUNC01    8'h01
`define AGP_RST_FUNC23    8'h20
`define AGP_RST_DIR01     8'h00
`define AGP_RST_DIR23     8'h00
`define AGP_RST_OUT       4'h0
`define AGP_RST_PULL      8'h00
`define AGP_RD_UNMAPPED   8'h00

// field positions shared by the paired-pin registers
`define AGP_HI_FIELD      6:4
`define AGP_LO_FIELD      2:0
`define AGP_HI_POL        7
`define AGP_LO_POL        3
`define AGP_OUT_FIELD     7:4
`define AGP_IN_FIELD      3:0
`define AGP_PD_FIELD      7:4

// function-select code that hands a pin to this block
`define AGP_FUNC_GPIO     3'h0

// deglitch filter length in clock cycles
`define AGP_DGL_CYCLES    4

`endif

/* design/agp_pkg.sv */
package agp_pkg;

  // direction / input-mode code of one pin
  typedef enum logic [2:0] {
    AGP_DIR_INPUT  = 3'b000,
    AGP_DIR_STICKY = 3'b001,
    AGP_DIR_TOGGLE = 3'b010,
    AGP_DIR_RAW    = 3'b011,
    AGP_DIR_OUTPUT = 3'b100,
    AGP_DIR_OPEN   = 3'b101,
    AGP_DIR_RSV6   = 3'b110,
    AGP_DIR_RSV7   = 3'b111
  } agp_dir_e;

  // everything one pin needs from the register file
  typedef struct packed {
    logic     gpioSel;
    logic     invert;
    agp_dir_e dir;
    logic     outVal;
  } agp_pincfg_s;

endpackage

/* design/agp_pin.sv */
`timescale 1ns/10ps
`include "agp_regs.svh"

module agp_pin #(
  parameter int DGL_CYCLES = `AGP_DGL_CYCLES
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 nrst,
  // configuration and status
  input  wire agp_pkg::agp_pincfg_s cfg,
  input  wire logic                 readClr,
  output logic                      status,
  // pad
  input  wire logic                 padIn,
  output logic                      padOut,
  output logic                      padOeN
);

  localparam int CW = $clog2(DGL_CYCLES + 1);

  logic          sync0;
  logic          sync1;
  logic          filt;
  logic          filtPrev;
  logic [CW-1:0] cnt;
  logic          next_filt;
  logic [CW-1:0] next_cnt;
  logic          next_status;
  logic          next_padOut;
  logic          next_padOeN;
  logic          raw;
  logic          drv;
  logic          held;

  // polarity applied once, after the synchroniser
  assign raw  = sync1 ^ cfg.invert;
  assign drv  = cfg.outVal ^ cfg.invert;
  assign held = readClr ? 1'b0 : status;

  // level must stay changed for DGL_CYCLES before the filter follows
  always_comb begin
    next_filt = filt;
    next_cnt  = '0;
    if (raw != filt) begin
      if (cnt == CW'(DGL_CYCLES - 1)) begin
        next_filt = raw;
      end else begin
        next_cnt = cnt + CW'(1);
      end
    end
  end

  // status bit per mode; a new event beats a same-cycle read clear
  always_comb begin
    unique case (cfg.dir)
      agp_pkg::AGP_DIR_STICKY: next_status = held | filt;
      agp_pkg::AGP_DIR_TOGGLE: next_status = held | (filt ^ filtPrev);
      agp_pkg::AGP_DIR_RAW:    next_status = raw;
      agp_pkg::AGP_DIR_INPUT,
      agp_pkg::AGP_DIR_OUTPUT,
      agp_pkg::AGP_DIR_OPEN,
      agp_pkg::AGP_DIR_RSV6,
      agp_pkg::AGP_DIR_RSV7:   next_status = filt;
    endcase
  end

  // pad drive; released unless the pin is handed to this block
  always_comb begin
    next_padOut = 1'b0;
    next_padOeN = 1'b1;
    if (cfg.gpioSel) begin
      unique case (cfg.dir)
        agp_pkg::AGP_DIR_OUTPUT: begin
          next_padOut = drv;
          next_padOeN = 1'b0;
        end
        agp_pkg::AGP_DIR_OPEN: begin
          next_padOeN = drv;                                        // only pulls low
        end
        agp_pkg::AGP_DIR_INPUT,
        agp_pkg::AGP_DIR_STICKY,
        agp_pkg::AGP_DIR_TOGGLE,
        agp_pkg::AGP_DIR_RAW,
        agp_pkg::AGP_DIR_RSV6,
        agp_pkg::AGP_DIR_RSV7: begin
          next_padOeN = 1'b1;
        end
      endcase
    end
  end

  // synchroniser, filter and outputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync0    <= 1'b0;
      sync1    <= 1'b0;
      filt     <= 1'b0;
      filtPrev <= 1'b0;
      cnt      <= '0;
      status   <= 1'b0;
      padOut   <= 1'b0;
      padOeN   <= 1'b1;
    end else begin
      sync0    <= padIn;
      sync1    <= sync0;
      filt     <= next_filt;
      filtPrev <= filt;
      cnt      <= next_cnt;
      status   <= next_status;
      padOut   <= next_padOut;
      padOeN   <= next_padOeN;
    end
  end

endmodule

/* design/agp_gpio.sv */
//Contract
//- pin3 mode in 0x13 bits 6-4, pin2 in bits 2-0; reset to input.
//- code 000 is deglitched input; code 011 reports the raw level.
//- code 001 is input with a sticky status bit holding an event.
//- 010 toggle detect, 100 driven output, 101 open drain; 110/111 reserved.
//- 0x14 bits 7-4 are output values for pins 3-0, reset zero.
//- 0x14 bits 3-0 return input level or sticky or toggle status, reset zero.
//- reading 0x14 clears every sticky status flag it reports; a flag whose event is still present in the read cycle stays set.
//- 0x15 bits 7-4: 0 keeps pin pull-down on, 1 turns it off.
//- a pin is general purpose only when its function select is 000.
//- each pin has a polarity bit; 1 inverts the signal.
//- pins 0 and 1 modes sit at 0x12 with the same encoding.
`timescale 1ns/10ps
`include "agp_regs.svh"

module agp_gpio #(
  parameter int NPINS      = 4,
  parameter int DGL_CYCLES = `AGP_DGL_CYCLES
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // register access from the control port
  input  wire logic [7:0]       regAddr,
  input  wire logic [7:0]       regWrData,
  input  wire logic             regWrEn,
  input  wire logic             regRdEn,
  output logic      [7:0]       regRdData,
  output logic                  regRdAck,
  // pads
  input  wire logic [NPINS-1:0] padIn,
  output logic      [NPINS-1:0] padOut,
  output logic      [NPINS-1:0] padOeN,
  output logic      [NPINS-1:0] pinPulldownOff,
  // function select handed to the pin mux
  output logic      [2:0]       pinFunctionSelect [NPINS]
);

  // register storage
  logic [7:0] funcReg01;
  logic [7:0] funcReg23;
  logic [7:0] dirReg01;
  logic [7:0] dirReg23;
  logic [3:0] outReg;
  logic [7:0] pullReg;
  logic [7:0] next_funcReg01;
  logic [7:0] next_funcReg23;
  logic [7:0] next_dirReg01;
  logic [7:0] next_dirReg23;
  logic [3:0] next_outReg;
  logic [7:0] next_pullReg;

  // read side
  logic [7:0]       next_regRdData;
  logic             next_regRdAck;
  logic             readClr;
  logic [NPINS-1:0] pinStatus;

  // register writes; reserved bits are stored as written, never steer logic
  always_comb begin
    next_funcReg01 = funcReg01;
    next_funcReg23 = funcReg23;
    next_dirReg01  = dirReg01;
    next_dirReg23  = dirReg23;
    next_outReg    = outReg;
    next_pullReg   = pullReg;
    if (regWrEn) begin
      unique case (regAddr)
        `AGP_ADDR_FUNC01: next_funcReg01 = regWrData;
        `AGP_ADDR_FUNC23: next_funcReg23 = regWrData;
        `AGP_ADDR_DIR01:  next_dirReg01  = regWrData;
        `AGP_ADDR_DIR23:  next_dirReg23  = regWrData;
        `AGP_ADDR_STATE:  next_outReg    = regWrData[`AGP_OUT_FIELD]; // status is read only
        `AGP_ADDR_PULL:   next_pullReg   = regWrData;
        default:          next_outReg    = outReg;                    // unmapped writes dropped
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      funcReg01 <= `AGP_RST_FUNC01;
      funcReg23 <= `AGP_RST_FUNC23;
      dirReg01  <= `AGP_RST_DIR01;
      dirReg23  <= `AGP_RST_DIR23;
      outReg    <= `AGP_RST_OUT;
      pullReg   <= `AGP_RST_PULL;
    end else begin
      funcReg01 <= next_funcReg01;
      funcReg23 <= next_funcReg23;
      dirReg01  <= next_dirReg01;
      dirReg23  <= next_dirReg23;
      outReg    <= next_outReg;
      pullReg   <= next_pullReg;
    end
  end

  // a read of the state register acknowledges captured events
  assign readClr = regRdEn && (regAddr == `AGP_ADDR_STATE);

  // read data is registered: the status is sampled on the same edge that clears it,
  // so the value returned is the one being acknowledged
  always_comb begin
    next_regRdData = regRdData;
    next_regRdAck  = regRdEn;
    if (regRdEn) begin
      unique case (regAddr)
        `AGP_ADDR_FUNC01: next_regRdData = funcReg01;
        `AGP_ADDR_FUNC23: next_regRdData = funcReg23;
        `AGP_ADDR_DIR01:  next_regRdData = dirReg01;
        `AGP_ADDR_DIR23:  next_regRdData = dirReg23;
        `AGP_ADDR_STATE:  next_regRdData = {outReg, pinStatus[3:0]};
        `AGP_ADDR_PULL:   next_regRdData = pullReg;
        default:          next_regRdData = `AGP_RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdData <= `AGP_RD_UNMAPPED;
      regRdAck  <= 1'b0;
    end else begin
      regRdData <= next_regRdData;
      regRdAck  <= next_regRdAck;
    end
  end

  // pull-down control comes straight from the register bits
  assign pinPulldownOff = pullReg[`AGP_PD_FIELD];

  // per-pin slices: even pins use the low field, odd pins the high field
  for (genvar i = 0; i < NPINS; i++) begin : g_pin
    agp_pkg::agp_pincfg_s cfg;
    logic [7:0]           funcSrc;
    logic [7:0]           dirSrc;
    logic [2:0]           funcField;
    logic [2:0]           dirField;
    logic                 polBit;

    assign funcSrc = (i < 2) ? funcReg01 : funcReg23;
    assign dirSrc  = (i < 2) ? dirReg01 : dirReg23;

    if (i % 2 == 0) begin : g_lo
      assign funcField = funcSrc[`AGP_LO_FIELD];
      assign dirField  = dirSrc[`AGP_LO_FIELD];
      assign polBit    = funcSrc[`AGP_LO_POL];
    end else begin : g_hi
      assign funcField = funcSrc[`AGP_HI_FIELD];
      assign dirField  = dirSrc[`AGP_HI_FIELD];
      assign polBit    = funcSrc[`AGP_HI_POL];
    end

    assign cfg.gpioSel = (funcField == `AGP_FUNC_GPIO);
    assign cfg.invert  = polBit;
    assign cfg.dir     = agp_pkg::agp_dir_e'(dirField);
    assign cfg.outVal  = outReg[i];
    assign pinFunctionSelect[i] = funcField;

    agp_pin #(
      .DGL_CYCLES (DGL_CYCLES)
    ) u_pin (
      .clk     (clk),
      .nrst    (nrst),
      .cfg     (cfg),
      .readClr (readClr),
      .status  (pinStatus[i]),
      .padIn   (padIn[i]),
      .padOut  (padOut[i]),
      .padOeN  (padOeN[i])
    );
  end

endmodule

/* verif/agp_pads.sv */
`timescale 1ns/10ps

module agp_pads (
  // clock for the float pattern
  input  wire logic       clk,
  // outside world
  input  wire logic [3:0] extLevel,
  input  wire logic [3:0] extDrive,
  // design side of the pads
  input  wire logic [3:0] padOut,
  input  wire logic [3:0] padOeN,
  input  wire logic [3:0] pinPulldownOff,
  output logic      [3:0] padIn
);
  logic [3:0] floatPat = 4'h5;

  // an unheld pad wanders so a stale level never reads as valid
  always @(posedge clk) floatPat <= ~floatPat;

  // device drive wins, then outside drive, then pull-down or float
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!padOeN[i]) padIn[i] = padOut[i];
      else if (extDrive[i]) padIn[i] = extLevel[i];
      else padIn[i] = pinPulldownOff[i] ? floatPat[i] : 1'b0;
    end
  end
endmodule

/* verif/agp_gpio_checker.sv */
`timescale 1ns/10ps

module agp_gpio_checker #(
  parameter int NPINS      = 4,
  parameter int DGL_CYCLES = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // register port
  input  wire logic [7:0]       regAddr,
  input  wire logic [7:0]       regWrData,
  input  wire logic             regWrEn,
  input  wire logic             regRdEn,
  input  wire logic [7:0]       regRdData,
  input  wire logic             regRdAck,
  // pads
  input  wire logic [NPINS-1:0] padIn,
  input  wire logic [NPINS-1:0] padOut,
  input  wire logic [NPINS-1:0] padOeN,
  input  wire logic [NPINS-1:0] pinPulldownOff,
  input  wire logic [2:0]       pinFunctionSelect [NPINS]
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_ack; regRdEn |=> regRdAck; endproperty
  a_ack: assert property (p_ack) else $error("read ack missing");
  property p_ackcause; regRdAck |-> $past(regRdEn); endproperty
  a_ackcause: assert property (p_ackcause) else $error("stray read ack");
  property p_hold; !regRdEn |=> $stable(regRdData); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_pull;
    regWrEn && regAddr == 8'h15 |=> pinPulldownOff == $past(regWrData[7:4]);
  endproperty
  a_pull: assert property (p_pull) else $error("pull-down control wrong");
  property p_out;
    regWrEn && regAddr == 8'h14 ##2 regRdEn && !regWrEn && regAddr == 8'h14
      |=> regRdData[7:4] == $past(regWrData[7:4], 3);
  endproperty
  a_out: assert property (p_out) else $error("output value readback wrong");
  property p_dir;
    regWrEn && regAddr == 8'h13 ##2 regRdEn && !regWrEn && regAddr == 8'h13
      |=> regRdData == $past(regWrData, 3);
  endproperty
  a_dir: assert property (p_dir) else $error("direction readback wrong");
  property p_func;
    regWrEn && regAddr == 8'h11 |=> pinFunctionSelect[2] == $past(regWrData[2:0]);
  endproperty
  a_func: assert property (p_func) else $error("function select wrong");
  property p_release; (pinFunctionSelect[3] != 3'h0) [*3] |-> padOeN[3]; endproperty
  a_release: assert property (p_release) else $error("pad driven off function");

  c_read: cover property (regRdAck && regRdData[3:0] != 4'h0);
  c_drive: cover property (!padOeN[3]);
  c_open: cover property (!padOeN[2] && !padOut[2]);
endmodule

bind agp_gpio agp_gpio_checker #(.NPINS(NPINS), .DGL_CYCLES(DGL_CYCLES)) u_chk (.*);

/* verif/testbench.sv */
`timescale 1ns/10ps

module testbench;
  typedef struct packed { logic [7:0] addr; logic [7:0] wd; logic [7:0] exp; } agp_row_s;
  logic       clk = 0, nrst = 0, regWrEn = 0, regRdEn = 0, regRdAck;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, rv;
  logic [3:0] padIn, padOut, padOeN, pinPulldownOff, extLevel = 4'h0, extDrive = 4'h0;
  logic [2:0] pinFunctionSelect [4];
  int         err_count = 0, checks = 0;
  agp_row_s   rows [5] = '{'{8'h13, 8'h45, 8'h45}, '{8'h12, 8'h32, 8'h32},
                           '{8'h15, 8'hA0, 8'hA0}, '{8'h11, 8'h00, 8'h00},
                           '{8'h20, 8'hFF, 8'h00}};

  agp_gpio #(.NPINS(4), .DGL_CYCLES(4)) dut (.*);
  agp_pads u_pads (.*);

  initial forever #4 clk = ~clk;

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); #1 regAddr = a; regWrData = d; regWrEn = 1;
    @(posedge clk); #1 regWrEn = 0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge clk); #1 regAddr = a; regRdEn = 1;
    @(posedge clk); #1 regRdEn = 0;
    for (n = 0; n < 4 && regRdAck !== 1'b1; n++) @(posedge clk);
    if (n == 4) begin err_count++; finish_test(); end
    d = regRdData;
  endtask

  task automatic do_reset();
    nrst = 0;
    repeat (8) @(posedge clk);
    #1 nrst = 1;
  endtask

  // pad drive changes settle after the extra output flop
  task automatic pads(input logic [7:0] a, input logic [7:0] d);
    wr(a, d);
    repeat (2) @(posedge clk);
    #1;
  endtask

  initial begin
    do_reset();
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wd);
      rd(rows[i].addr, rv);
      chk("row readback", rv, rows[i].exp);
    end
    chk("pull-down pins", {4'h0, pinPulldownOff}, 8'h0A);
    $display("table test done");
    pads(8'h14, 8'hC0);
    chk("push-pull pin3", {padOeN[3], padOut[3]}, 8'h01);
    chk("open-drain pin2", {padOeN[2], padOut[2]}, 8'h02);
    pads(8'h11, 8'h88);
    chk("inverted pins", {padOeN[3:2], padOut[3:2]}, 8'h00);
    pads(8'h11, 8'h10);
    chk("routed pin3", {7'h0, padOeN[3]}, 8'h01);
    $display("output test done");
    wr(8'h15, 8'h00); // pull-downs on so no pad floats during the input cases
    wr(8'h11, 8'h00);
    wr(8'h13, 8'h01);
    wr(8'h14, 8'h00);
    rd(8'h14, rv);
    chk("output values cleared", {4'h0, rv[7:4]}, 8'h00);
    extDrive = 4'hC; extLevel = 4'hC;
    repeat (10) @(posedge clk);
    rd(8'h14, rv);
    chk("plain and sticky high", {4'h0, rv[3:0]}, 8'h0C);
    #1 extDrive = 4'h0;
    repeat (10) @(posedge clk);
    rd(8'h14, rv);
    chk("sticky kept", {4'h0, rv[3:0]}, 8'h04);
    rd(8'h14, rv);
    chk("sticky cleared", {4'h0, rv[3:0]}, 8'h00);
    wr(8'h13, 8'h20);
    rd(8'h14, rv);
    extDrive = 4'h8;
    repeat (10) @(posedge clk);
    rd(8'h14, rv);
    chk("toggle seen", {4'h0, rv[3]}, 8'h01);
    rd(8'h14, rv);
    chk("toggle cleared", {4'h0, rv[3]}, 8'h00);
    #1 extDrive = 4'h0;
    wr(8'h13, 8'h03);
    repeat (12) @(posedge clk);
    #1 extDrive = 4'hC;
    repeat (2) @(posedge clk);
    #1 extDrive = 4'h0;
    @(posedge clk); #1 regAddr = 8'h14; regRdEn = 1;
    @(posedge clk); #1 regRdEn = 0;
    chk("short pulse raw vs filtered", {4'h0, regRdData[3:0]}, 8'h04);
    $display("input test done");
    do_reset();
    foreach (rows[i]) begin
      rd(rows[i].addr, rv);
      chk("reset value", rv, (rows[i].addr == 8'h11) ? 8'h20 : 8'h00);
    end
    chk("reset pads", {padOeN, padOut}, 8'hF0);
    $display("reset test done");
    finish_test();
  end
endmodule
